//--- rtl/ledsup_pkg.sv
// package: constants and types for the led driver fault supervisor
package ledsup_pkg;
	localparam int NUM_CH       = 5;
	localparam int NUM_DISP     = 2;
	localparam int NUM_KEY      = 3;
	localparam int DISP_CODE_W  = 7;
	localparam int KEY_CODE_W   = 5;
	localparam logic [6:0] DISP_CODE_MAX = 7'h7F; // 25.25 mA
	localparam logic [4:0] KEY_CODE_MAX  = 5'h1F; // 5.00 mA
	localparam logic [6:0] DISP_CODE_RST = 7'h00;
	localparam logic [4:0] KEY_CODE_RST  = 5'h00;
	// global fault status bit positions
	localparam int GF_OVERVOLT  = 0;
	localparam int GF_OVERTEMP  = 1;
	localparam int GF_OPENDIODE = 2;
	localparam int GF_W         = 3;
	// timing
	localparam int  CLK_MHZ      = 200;
	localparam int  DEBOUNCE_MS  = 16;
	localparam longint DEBOUNCE_CYC_L = longint'(DEBOUNCE_MS) * 1000 * 1000
		* CLK_MHZ / 1000;
	localparam int  DEBOUNCE_CYC = int'(DEBOUNCE_CYC_L);
	localparam int  DBC_W        = 23;
	// power state, one-hot
	typedef enum logic [2:0] {
		LEDSUP_OFF     = 3'b001,
		LEDSUP_SHUTDN  = 3'b010,
		LEDSUP_STANDBY = 3'b100
	} ledsup_pwr_t;
	// converter sequence, one-hot
	typedef enum logic [3:0] {
		LEDSUP_IDLE  = 4'b0001,
		LEDSUP_CHECK = 4'b0010,
		LEDSUP_RUN   = 4'b0100,
		LEDSUP_HOLD  = 4'b1000
	} ledsup_cnv_t;
endpackage

//--- rtl/ledsup_dbc_if.sv
// interface: debounce bank request and expiry signals
`timescale 1ns/10ps
interface ledsup_dbc_if #(parameter int N = 5);
	logic [N-1:0] fault_raw;
	logic         clear;
	logic [N-1:0] expired;
	modport ctrl (output fault_raw, output clear, input expired);
	modport bank (input fault_raw, input clear, output expired);
endinterface

//--- rtl/ledsup_dbc.sv
// module: per-channel fault debounce counters
`timescale 1ns/10ps
module ledsup_dbc #(
	parameter int CYCLES = 3200000,
	parameter int W      = 23
) (
	// clock and reset
	input  wire logic clock_i,
	input  wire logic rst_i,
	// debounce bank
	ledsup_dbc_if.bank dbc
);
	import ledsup_pkg::*;
	localparam logic [W-1:0] LAST = W'(CYCLES - 1);
	logic [W-1:0] cnt      [NUM_CH];
	logic [W-1:0] next_cnt [NUM_CH];
	logic [NUM_CH-1:0] next_exp;
	logic [NUM_CH-1:0] exp_q;

	// count while a fault persists, pulse once at expiry
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			next_cnt[i] = cnt[i];
			next_exp[i] = 1'b0;
			if (dbc.clear || !dbc.fault_raw[i]) begin
				next_cnt[i] = '0;
			end else if (cnt[i] == LAST) begin
				next_exp[i] = 1'b1;
				next_cnt[i] = '0;
			end else begin
				next_cnt[i] = cnt[i] + W'(1);
			end
		end
	end

	// register counters
	always_ff @(posedge clock_i) begin
		for (int i = 0; i < NUM_CH; i++) begin
			cnt[i] <= rst_i ? '0 : next_cnt[i];
		end
		exp_q <= rst_i ? '0 : next_exp;
	end
	assign dbc.expired = exp_q;
endmodule

//--- rtl/ledsup_top.sv
// module: led driver fault supervisor top
`timescale 1ns/10ps
// Functional notes
// - display channels take 7-bit current code
// - keypad channels take 5-bit current code
// - shutdown holds registers reset, outputs off
// - supply valid enters standby, accepts commands
// - any enable set starts converter
// - converter off tristates switch and channels
// - fault comparators gated by channel enable
// - one fault flag per channel
// - debounced fault latches flag, clears enable
// - overvoltage preempts pending channel fault
// - alternate-supply keypad: open detection only
// - overvoltage while running clears enables, sets bit 0
// - converter may restart below recovery level
// - low output before start: bit 2
// - overtemperature clears enables, sets bit 1
// - channel status read clears, re-enables
// - global fault holds standby until read
module ledsup_top #(
	parameter int DEBOUNCE_CYCLES = ledsup_pkg::DEBOUNCE_CYC
) (
	// clock and reset
	input  wire logic                              clock_i,
	input  wire logic                              rst_i,
	// supply monitors (asynchronous)
	input  wire logic                              logic_supply_ok_i,
	input  wire logic                              input_above_uvlo_i,
	// host command port
	input  wire logic                              en_write_i,
	input  wire logic [ledsup_pkg::NUM_CH-1:0]     en_data_i,
	input  wire logic                              code_write_i,
	input  wire logic [2:0]                        code_sel_i,
	input  wire logic [ledsup_pkg::DISP_CODE_W-1:0] code_data_i,
	input  wire logic [ledsup_pkg::NUM_KEY-1:0]    supply_select_control_i,
	input  wire logic                              chan_status_read_i,
	input  wire logic                              glob_status_read_i,
	// analog comparators (asynchronous)
	input  wire logic [ledsup_pkg::NUM_CH-1:0]     open_cmp_i,
	input  wire logic [ledsup_pkg::NUM_CH-1:0]     short_cmp_i,
	input  wire logic                              overvolt_cmp_i,
	input  wire logic                              recover_cmp_i,
	input  wire logic                              overtemp_cmp_i,
	input  wire logic                              out_present_cmp_i,
	// status and control outputs
	output logic                                   standby_o,
	output logic                                   shutdown_o,
	output logic [ledsup_pkg::NUM_CH-1:0]          chan_enable_o,
	output logic [ledsup_pkg::NUM_CH-1:0]          channel_fault_status_o,
	output logic [ledsup_pkg::GF_W-1:0]            global_fault_status_o,
	output logic [ledsup_pkg::NUM_CH-1:0]          cmp_enable_o,
	output logic [ledsup_pkg::NUM_CH-1:0]          short_det_enable_o,
	output logic                                   converter_on_o,
	output logic                                   switch_node_oe_o,
	output logic [ledsup_pkg::NUM_CH-1:0]          chan_drive_oe_o,
	output logic [ledsup_pkg::DISP_CODE_W-1:0]     display_channel_a_code_o,
	output logic [ledsup_pkg::DISP_CODE_W-1:0]     display_channel_b_code_o,
	output logic [ledsup_pkg::KEY_CODE_W-1:0]      keypad_channel_a_code_o,
	output logic [ledsup_pkg::KEY_CODE_W-1:0]      keypad_channel_b_code_o,
	output logic [ledsup_pkg::KEY_CODE_W-1:0]      keypad_channel_c_code_o
);
	import ledsup_pkg::*;
	localparam int NS = 2 * NUM_CH + 6;

	// two-flop synchronisers for all asynchronous inputs
	logic [NS-1:0] sync1;
	logic [NS-1:0] sync2;
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			sync1 <= '0;
			sync2 <= '0;
		end else begin
			sync1 <= {logic_supply_ok_i, input_above_uvlo_i, open_cmp_i,
				short_cmp_i, overvolt_cmp_i, recover_cmp_i,
				overtemp_cmp_i, out_present_cmp_i};
			sync2 <= sync1;
		end
	end
	logic              vdd_ok, vin_ok, ov, rec, ot, present;
	logic [NUM_CH-1:0] open_s, short_s;
	assign {vdd_ok, vin_ok, open_s, short_s, ov, rec, ot, present} = sync2;

	// registers
	ledsup_pwr_t            pwr, next_pwr;
	ledsup_cnv_t            cnv, next_cnv;
	logic [NUM_CH-1:0]      en, next_en;
	logic [NUM_CH-1:0]      cfs, next_cfs;
	logic [GF_W-1:0]        gfs, next_gfs;
	logic [DISP_CODE_W-1:0] dcode [NUM_DISP];
	logic [DISP_CODE_W-1:0] next_dcode [NUM_DISP];
	logic [KEY_CODE_W-1:0]  kcode [NUM_KEY];
	logic [KEY_CODE_W-1:0]  next_kcode [NUM_KEY];
	logic [NUM_KEY-1:0]     alt, next_alt;
	logic                   active;
	logic [NUM_CH-1:0]      short_gate;

	// short detection suppressed on alternate-supply keypad channels
	assign short_gate = {~alt, {NUM_DISP{1'b1}}};

	ledsup_dbc_if #(.N(NUM_CH)) dbc_if ();
	// raw fault gated by enable; open or short merged per channel
	assign dbc_if.fault_raw = en & (open_s | (short_s & short_gate));
	assign dbc_if.clear = !active;

	ledsup_dbc #(
		.CYCLES (DEBOUNCE_CYCLES),
		.W      (DBC_W)
	) u_dbc (
		.clock_i (clock_i),
		.rst_i   (rst_i),
		.dbc     (dbc_if.bank)
	);

	// supply valid means registers may leave reset
	assign active = vdd_ok && vin_ok;

	// next-state for power, converter, enables and status
	always_comb begin
		logic glob_evt;
		glob_evt   = 1'b0;
		next_pwr   = pwr;
		next_cnv   = cnv;
		next_en    = en;
		next_cfs   = cfs;
		next_gfs   = gfs;
		next_dcode = dcode;
		next_kcode = kcode;
		next_alt   = alt;
		if (!active) begin
			// registers held at reset while logic supply is low
			next_pwr   = vin_ok ? LEDSUP_SHUTDN : LEDSUP_OFF;
			next_cnv   = LEDSUP_IDLE;
			next_en    = '0;
			next_cfs   = '0;
			next_gfs   = '0;
			next_alt   = '0;
			next_dcode = '{default: DISP_CODE_RST};
			next_kcode = '{default: KEY_CODE_RST};
		end else begin
			next_pwr = LEDSUP_STANDBY;
			// host writes
			if (code_write_i) begin
				if (code_sel_i < 3'(NUM_DISP)) begin
					next_dcode[code_sel_i[0]] = code_data_i;
				end else if (code_sel_i < 3'(NUM_CH)) begin
					next_kcode[2'(code_sel_i - 3'(NUM_DISP))] =
						code_data_i[KEY_CODE_W-1:0];
				end
			end
			next_alt = supply_select_control_i;
			// enables refused until the global status is read
			if (en_write_i && gfs == '0) begin
				next_en = en_data_i;
			end
			// status read clears flags and re-enables strings
			if (chan_status_read_i) begin
				next_cfs = '0;
				if (gfs == '0) begin
					next_en = next_en | cfs;
				end
			end
			if (glob_status_read_i) begin
				next_gfs = '0;
			end
			// debounced channel fault: set wins over read-clear
			next_cfs = next_cfs | dbc_if.expired;
			next_en  = next_en & ~dbc_if.expired;
			// global faults preempt pending channel faults
			if (ov && cnv == LEDSUP_RUN) begin
				next_gfs[GF_OVERVOLT] = 1'b1;
				glob_evt = 1'b1;
			end
			if (ot) begin
				next_gfs[GF_OVERTEMP] = 1'b1;
				glob_evt = 1'b1;
			end
			unique case (cnv)
				LEDSUP_IDLE: begin
					// start when any enable is on and no fault held
					if (next_en != '0 && gfs == '0 && !glob_evt) begin
						next_cnv = LEDSUP_CHECK;
					end
				end
				LEDSUP_CHECK: begin
					if (!present) begin
						next_gfs[GF_OPENDIODE] = 1'b1;
						glob_evt = 1'b1;
					end else begin
						next_cnv = LEDSUP_RUN;
					end
				end
				LEDSUP_RUN: begin
					if (en == '0) begin
						next_cnv = LEDSUP_IDLE;
					end
				end
				LEDSUP_HOLD: begin
					// wait below recovery level before restart
					if (rec) begin
						next_cnv = LEDSUP_IDLE;
					end
				end
				default: next_cnv = LEDSUP_IDLE;
			endcase
			if (glob_evt) begin
				next_en  = '0;
				next_cfs = next_cfs & ~dbc_if.expired;
				next_cnv = next_gfs[GF_OVERVOLT] ? LEDSUP_HOLD : LEDSUP_IDLE;
			end
		end
	end

	// register state
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			pwr   <= LEDSUP_OFF;
			cnv   <= LEDSUP_IDLE;
			en    <= '0;
			cfs   <= '0;
			gfs   <= '0;
			alt   <= '0;
			dcode <= '{default: DISP_CODE_RST};
			kcode <= '{default: KEY_CODE_RST};
		end else begin
			pwr   <= next_pwr;
			cnv   <= next_cnv;
			en    <= next_en;
			cfs   <= next_cfs;
			gfs   <= next_gfs;
			alt   <= next_alt;
			dcode <= next_dcode;
			kcode <= next_kcode;
		end
	end

	// registered outputs
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			standby_o                <= 1'b0;
			shutdown_o               <= 1'b0;
			chan_enable_o            <= '0;
			channel_fault_status_o   <= '0;
			global_fault_status_o    <= '0;
			cmp_enable_o             <= '0;
			short_det_enable_o       <= '0;
			converter_on_o           <= 1'b0;
			switch_node_oe_o         <= 1'b0;
			chan_drive_oe_o          <= '0;
			display_channel_a_code_o <= '0;
			display_channel_b_code_o <= '0;
			keypad_channel_a_code_o  <= '0;
			keypad_channel_b_code_o  <= '0;
			keypad_channel_c_code_o  <= '0;
		end else begin
			standby_o                <= next_pwr == LEDSUP_STANDBY;
			shutdown_o               <= next_pwr == LEDSUP_SHUTDN;
			chan_enable_o            <= next_en;
			channel_fault_status_o   <= next_cfs;
			global_fault_status_o    <= next_gfs;
			cmp_enable_o             <= next_en;
			short_det_enable_o       <= next_en & {~next_alt, 2'b11};
			converter_on_o           <= next_cnv == LEDSUP_RUN;
			// converter off: switch node and channels undriven
			switch_node_oe_o         <= next_cnv == LEDSUP_RUN;
			chan_drive_oe_o          <= (next_cnv == LEDSUP_RUN) ? next_en : '0;
			display_channel_a_code_o <= next_dcode[0];
			display_channel_b_code_o <= next_dcode[1];
			keypad_channel_a_code_o  <= next_kcode[0];
			keypad_channel_b_code_o  <= next_kcode[1];
			keypad_channel_c_code_o  <= next_kcode[2];
		end
	end

	// overvoltage while running clears enables next cycle
	AST_OV_CLEARS: assert property (@(posedge clock_i) disable iff (rst_i)
		(active && ov && cnv == LEDSUP_RUN) |=> (en == '0 && gfs[GF_OVERVOLT]))
		else $error("overvoltage did not clear enables");
	// overtemperature sets bit 1 and clears enables
	AST_OT_CLEARS: assert property (@(posedge clock_i) disable iff (rst_i)
		(active && ot) |=> (en == '0 && gfs[GF_OVERTEMP]))
		else $error("overtemperature not handled");
	// debounce expiry latches the channel fault flag
	AST_DBC_LATCH: assert property (@(posedge clock_i) disable iff (rst_i)
		(active && dbc_if.expired != '0 && !ov && !ot && cnv != LEDSUP_CHECK)
		|=> ((cfs & $past(dbc_if.expired)) == $past(dbc_if.expired)))
		else $error("channel fault not latched");
	// switch node undriven whenever converter is off
	AST_TRISTATE: assert property (@(posedge clock_i) disable iff (rst_i)
		cnv != LEDSUP_RUN |-> (!switch_node_oe_o && chan_drive_oe_o == '0))
		else $error("driver enabled with converter off");
	// supply low holds enables and global status cleared, converter idle
	AST_SHUTDN: assert property (@(posedge clock_i) disable iff (rst_i)
		!active |=> (en == '0 && gfs == '0 && cnv == LEDSUP_IDLE))
		else $error("state not held in shutdown");
	// missing output before start flags open diode
	AST_OPEN_DIODE: assert property (@(posedge clock_i) disable iff (rst_i)
		(active && cnv == LEDSUP_CHECK && !present) |=>
		(gfs[GF_OPENDIODE] && en == '0 && cnv != LEDSUP_RUN))
		else $error("open diode not flagged");
	// held global fault keeps converter from starting
	AST_HOLD_STBY: assert property (@(posedge clock_i) disable iff (rst_i)
		(cnv == LEDSUP_IDLE && gfs != '0) |=> cnv != LEDSUP_CHECK)
		else $error("restart with global fault pending");
	// enable set starts the presence check
	AST_START: assert property (@(posedge clock_i) disable iff (rst_i)
		(active && cnv == LEDSUP_IDLE && en_write_i && en_data_i != '0 &&
		gfs == '0 && !ot && !glob_status_read_i) |=> cnv == LEDSUP_CHECK)
		else $error("converter did not start");
	COV_RUN: cover property (@(posedge clock_i) cnv == LEDSUP_RUN);
	COV_OV: cover property (@(posedge clock_i) cnv == LEDSUP_HOLD);
	COV_CHFLT: cover property (@(posedge clock_i) cfs != '0);
endmodule

//--- sim/ledsup_host_model.sv
// host model: command strobes and status read-clear pulses
`timescale 1ns/10ps
module ledsup_host_model (
	// clock
	input  wire logic                          clock_i,
	// strobes and data toward the supervisor
	output logic                               en_write_o,
	output logic [ledsup_pkg::NUM_CH-1:0]      en_data_o,
	output logic                               code_write_o,
	output logic [2:0]                         code_sel_o,
	output logic [ledsup_pkg::DISP_CODE_W-1:0] code_data_o,
	output logic                               chan_read_o,
	output logic                               glob_read_o
);
	import ledsup_pkg::*;
	// strobes idle from time zero
	initial begin
		en_write_o = 1'b0;
		en_data_o = '0;
		code_write_o = 1'b0;
		code_sel_o = '0;
		code_data_o = '0;
		chan_read_o = 1'b0;
		glob_read_o = 1'b0;
	end
	// one-cycle channel enable write
	task automatic wr_en(input logic [NUM_CH-1:0] d);
		@(posedge clock_i);
		en_write_o <= 1'b1;
		en_data_o <= d;
		@(posedge clock_i);
		en_write_o <= 1'b0;
	endtask
	// one-cycle current code write
	task automatic wr_code(input logic [2:0] s, input logic [6:0] d);
		@(posedge clock_i);
		code_write_o <= 1'b1;
		code_sel_o <= s;
		code_data_o <= d;
		@(posedge clock_i);
		code_write_o <= 1'b0;
	endtask
	// read-clear pulse; a channel read re-arms flagged strings,
	// a global read must come before the host re-enables
	task automatic rd(input logic glob);
		@(posedge clock_i);
		chan_read_o <= ~glob;
		glob_read_o <= glob;
		@(posedge clock_i);
		chan_read_o <= 1'b0;
		glob_read_o <= 1'b0;
	endtask
endmodule

//--- sim/tb.sv
// testbench for the led driver fault supervisor
`timescale 1ns/10ps
module tb;
	import ledsup_pkg::*;
	localparam int DBC = 16;
	logic clock_i, rst_i, logic_supply_ok_i, input_above_uvlo_i;
	logic en_write_i, code_write_i, chan_status_read_i;
	logic glob_status_read_i, overvolt_cmp_i, recover_cmp_i;
	logic overtemp_cmp_i, out_present_cmp_i, standby_o, shutdown_o;
	logic converter_on_o, switch_node_oe_o;
	logic [NUM_CH-1:0] en_data_i, open_cmp_i, short_cmp_i;
	logic [NUM_CH-1:0] chan_enable_o, channel_fault_status_o;
	logic [NUM_CH-1:0] cmp_enable_o, short_det_enable_o;
	logic [NUM_CH-1:0] chan_drive_oe_o;
	logic [2:0] code_sel_i, global_fault_status_o;
	logic [NUM_KEY-1:0] supply_select_control_i;
	logic [DISP_CODE_W-1:0] code_data_i, display_channel_a_code_o;
	logic [DISP_CODE_W-1:0] display_channel_b_code_o;
	logic [KEY_CODE_W-1:0] keypad_channel_a_code_o;
	logic [KEY_CODE_W-1:0] keypad_channel_b_code_o;
	logic [KEY_CODE_W-1:0] keypad_channel_c_code_o;
	int fails, n_checks, cycles;

	ledsup_top #(.DEBOUNCE_CYCLES(DBC)) u_dut (.clock_i, .rst_i,
		.logic_supply_ok_i, .input_above_uvlo_i, .en_write_i,
		.en_data_i, .code_write_i, .code_sel_i, .code_data_i,
		.supply_select_control_i, .chan_status_read_i,
		.glob_status_read_i, .open_cmp_i, .short_cmp_i,
		.overvolt_cmp_i, .recover_cmp_i, .overtemp_cmp_i,
		.out_present_cmp_i, .standby_o, .shutdown_o, .chan_enable_o,
		.channel_fault_status_o, .global_fault_status_o,
		.cmp_enable_o, .short_det_enable_o, .converter_on_o,
		.switch_node_oe_o, .chan_drive_oe_o,
		.display_channel_a_code_o, .display_channel_b_code_o,
		.keypad_channel_a_code_o, .keypad_channel_b_code_o,
		.keypad_channel_c_code_o);

	ledsup_host_model u_host (.clock_i, .en_write_o(en_write_i),
		.en_data_o(en_data_i), .code_write_o(code_write_i),
		.code_sel_o(code_sel_i), .code_data_o(code_data_i),
		.chan_read_o(chan_status_read_i),
		.glob_read_o(glob_status_read_i));

	// 200 MHz clock
	initial begin
		clock_i = 1'b0;
		forever #2.5 clock_i = ~clock_i;
	end

	// cycle ceiling cuts a hang short
	always @(posedge clock_i) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			fails = fails + 1;
			end_sim();
		end
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge clock_i);
	endtask

	// wait, then step past the edge so outputs have settled
	task automatic wt(input int n);
		cyc(n);
		#1;
	endtask

	task automatic chk(input logic [63:0] seen, exp, input string m);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: %s got %0h want %0h",
				$time, m, seen, exp);
		end
	endtask

	task automatic tdone(input string m);
		$display("test %s done", m);
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// main sequence
	initial begin
		rst_i = 1'b1;
		logic_supply_ok_i = 1'b1;
		input_above_uvlo_i = 1'b1;
		supply_select_control_i = '0;
		open_cmp_i = '0;
		short_cmp_i = '0;
		overvolt_cmp_i = 1'b0;
		recover_cmp_i = 1'b1;
		overtemp_cmp_i = 1'b0;
		out_present_cmp_i = 1'b1;
		cyc(8);
		@(posedge clock_i) rst_i <= 1'b0;
		wt(6);
		chk({standby_o, shutdown_o, switch_node_oe_o, chan_drive_oe_o,
			chan_enable_o}, 13'h1000, "idle");
		// every channel to top code, then an out-of-range select
		for (int i = 0; i < NUM_CH; i++)
			u_host.wr_code(3'(i), 7'h7F);
		u_host.wr_code(3'h5, 7'h00);
		wt(3);
		chk({display_channel_a_code_o, display_channel_b_code_o},
			14'h3FFF, "disp");
		chk({keypad_channel_a_code_o, keypad_channel_b_code_o,
			keypad_channel_c_code_o}, 15'h7FFF, "key");
		tdone("codes");
		u_host.wr_en(5'h1F);
		wt(6);
		chk({converter_on_o, switch_node_oe_o, chan_drive_oe_o},
			7'h7F, "run");
		chk({chan_enable_o, cmp_enable_o}, 10'h3FF, "cmp");
		@(posedge clock_i);
		supply_select_control_i <= 3'h1;
		wt(4);
		chk(short_det_enable_o, 5'h1B, "alt");
		@(posedge clock_i);
		supply_select_control_i <= 3'h0;
		tdone("enable");
		// open on one string, short on another
		@(posedge clock_i);
		open_cmp_i <= 5'h02;
		@(posedge clock_i);
		short_cmp_i <= 5'h08;
		wt(8);
		chk(channel_fault_status_o, 5'h00, "early");
		wt(DBC + 2);
		chk(channel_fault_status_o, 5'h0A, "flag");
		chk(chan_enable_o, 5'h15, "cut");
		@(posedge clock_i);
		open_cmp_i <= 5'h00;
		@(posedge clock_i);
		short_cmp_i <= 5'h00;
		u_host.rd(1'b0);
		wt(4);
		chk({channel_fault_status_o, chan_enable_o}, 10'h01F,
			"rearm");
		tdone("channel fault");
		// overvoltage while a string fault is still pending
		@(posedge clock_i);
		open_cmp_i <= 5'h01;
		wt(6);
		@(posedge clock_i);
		overvolt_cmp_i <= 1'b1;
		@(posedge clock_i);
		recover_cmp_i <= 1'b0;
		wt(4);
		@(posedge clock_i);
		overvolt_cmp_i <= 1'b0;
		wt(DBC);
		chk({global_fault_status_o, channel_fault_status_o}, 8'h20,
			"ov");
		chk({converter_on_o, switch_node_oe_o, chan_enable_o}, 7'h00,
			"ovoff");
		@(posedge clock_i);
		open_cmp_i <= 5'h00;
		// enable without the status read is refused
		u_host.wr_en(5'h1F);
		wt(6);
		chk({converter_on_o, chan_enable_o}, 6'h00, "hold");
		u_host.rd(1'b1);
		u_host.wr_en(5'h1F);
		wt(6);
		chk({global_fault_status_o, converter_on_o}, 4'h0,
			"wait");
		@(posedge clock_i);
		recover_cmp_i <= 1'b1;
		wt(8);
		chk(converter_on_o, 1'b1, "restart");
		tdone("overvoltage");
		@(posedge clock_i);
		overtemp_cmp_i <= 1'b1;
		wt(5);
		chk({global_fault_status_o, converter_on_o, chan_enable_o},
			9'h080, "hot");
		@(posedge clock_i);
		overtemp_cmp_i <= 1'b0;
		cyc(4);
		u_host.rd(1'b1);
		tdone("overtemp");
		@(posedge clock_i);
		out_present_cmp_i <= 1'b0;
		u_host.wr_en(5'h01);
		wt(6);
		chk({global_fault_status_o, converter_on_o, chan_enable_o},
			9'h100, "diode");
		u_host.rd(1'b1);
		@(posedge clock_i);
		out_present_cmp_i <= 1'b1;
		tdone("open diode");
		// logic supply drops: shutdown resets state, ignores commands
		@(posedge clock_i);
		logic_supply_ok_i <= 1'b0;
		wt(5);
		u_host.wr_en(5'h1F);
		wt(4);
		chk({shutdown_o, standby_o, chan_enable_o,
			display_channel_a_code_o}, 14'h2000, "shut");
		chk({converter_on_o, switch_node_oe_o}, 2'h0, "off");
		// main input drops too: off state, neither flag shown
		@(posedge clock_i);
		input_above_uvlo_i <= 1'b0;
		wt(5);
		chk({shutdown_o, standby_o}, 2'h0, "offstate");
		// supplies return: standby with codes back at reset value
		@(posedge clock_i);
		logic_supply_ok_i <= 1'b1;
		input_above_uvlo_i <= 1'b1;
		wt(6);
		chk({standby_o, display_channel_a_code_o}, 8'h80,
			"back");
		tdone("shutdown");
		end_sim();
	end
endmodule
